// *** core/opb_params.svh ***
// Register map, field positions and reset values of the offset/power bank
// How it works
// [R1] Index 0x14 holds channel A offset bits 7:0
// [R2] Index 0x15 holds channel B offset bits 7:0
// [R3] Index 0x16 bits 7:3 hold A offset 12:8
// [R4] Index 0x17 bits 7:3 hold B offset 12:8
// [R5] Applied offsets are added to each sample stream
// [R6] Writing index 0x14 syncs all four offset registers
// [R7] Other offset writes leave applied offset unchanged
// [R8] Host writes index 0x14 last
// [R9] Index 0x17 bit 2 selects four-wire serial mode
// [R10] Index 0x17 bit 1 sleeps A clock path
// [R11] Host stops clock paths only in power-down
// [R12] Index 0x17 bit 0 sleeps B clock path
// [R13] Index 0x18 bit 7 enables temperature sensor
// [R14] Index 0x18 bit 6 sleeps clock, strobe receivers
// [R15] Index 0x18 bit 3 sleeps channel B
// [R16] Index 0x18 bit 2 sleeps channel A
// [R17] Index 0x19 bit 2 selects external reference
// [R18] Applied offsets are zero after reset
// [R19] Host preserves reserved bit defaults
`ifndef OPB_PARAMS_SVH
`define OPB_PARAMS_SVH

// ---------------------------------------------------------------
// Register indices (byte address is four times the index)
// ---------------------------------------------------------------
`define OPB_IDX_OFS_A_LO   6'h14
`define OPB_IDX_OFS_B_LO   6'h15
`define OPB_IDX_OFS_A_HI   6'h16
`define OPB_IDX_OFS_B_HI   6'h17
`define OPB_IDX_PWR        6'h18
`define OPB_IDX_REF        6'h19
`define OPB_IDX_FIRST      `OPB_IDX_OFS_A_LO
`define OPB_IDX_LAST       `OPB_IDX_REF
`define OPB_SLOT(idx)      3'((idx) - `OPB_IDX_FIRST)
`define OPB_NUM_REGS       6

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define OPB_HI_MSB         7
`define OPB_HI_LSB         3
`define OPB_FOUR_WIRE_BIT  2
`define OPB_CLK_SLP_A_BIT  1
`define OPB_CLK_SLP_B_BIT  0
`define OPB_TEMP_EN_BIT    7
`define OPB_RECV_SLP_BIT   6
`define OPB_SLEEP_B_BIT    3
`define OPB_SLEEP_A_BIT    2
`define OPB_EXT_REF_BIT    2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define OPB_RST_DEFAULT    8'h00
`define OPB_RST_PWR        8'h83

`endif

// *** core/opb_pkg.sv ***
// Types shared by the offset/power configuration bank
package opb_pkg;

  typedef enum logic [1:0] {
    OPB_OKAY   = 2'b00,
    OPB_SLVERR = 2'b10
  } opb_resp_t;

  typedef enum logic [0:0] {
    OPB_WR_IDLE = 1'b0,
    OPB_WR_RESP = 1'b1
  } opb_wr_st_t;

  typedef enum logic [0:0] {
    OPB_RD_IDLE = 1'b0,
    OPB_RD_RESP = 1'b1
  } opb_rd_st_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } opb_pair_t;

  typedef struct packed {
    logic fourWireSerialSel;
    logic clkPathSleepA;
    logic clkPathSleepB;
    logic tempSenseEn;
    logic clkRecvSleep;
    logic chanSleepB;
    logic chanSleepA;
    logic extRefSel;
  } opb_ctrl_t;

endpackage

// *** core/opb_offset_add.sv ***
// Registered adder that applies one channel's offset to its sample stream
`timescale 1ns/1ps

module opb_offset_add
  import opb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Sample and offset
  input  wire logic [15:0] sampleIn,
  input  wire logic [12:0] offset,
  output logic      [15:0] sampleOut
);

  wire logic [15:0] offsetExt;
  wire logic [15:0] sumD;

  assign offsetExt = {{3{offset[12]}}, offset};
  assign sumD      = 16'(sampleIn + offsetExt); // [R5]

  always_ff @(posedge clk) begin
    if (rst) begin
      sampleOut <= 16'h0000;
    end else begin
      sampleOut <= sumD;
    end
  end

  sum_offset_a: assert property (@(posedge clk) disable iff (rst) // [R5]
    1'b1 |=> sampleOut == 16'($past(sampleIn) + {{3{$past(offset[12])}}, $past(offset)}))
    else $error("sample output is not input plus offset");

endmodule

// *** core/opb_bank.sv ***
// Offset and power configuration bank behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "opb_params.svh"

module opb_bank
  import opb_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Write address channel
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // Write data channel
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // Write response channel
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read address channel
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // Read data channel
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Sample streams
  input  wire opb_pair_t   sampleIn,
  output wire opb_pair_t   sampleOut,
  // Offset sync and applied offsets
  output logic             offsetSync,
  output logic [12:0]      appliedOffsetA,
  output logic [12:0]      appliedOffsetB,
  // Power, sleep and reference controls
  output wire opb_ctrl_t   ctrlOut,
  // Alarm pin sharing
  input  wire logic        serialReadData,
  input  wire logic        alarmSource,
  output logic             alarmReadDataPin
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  function automatic logic [3:0] regSlot(input logic [7:0] addr);
    logic [5:0] idx;
    idx = addr[7:2];
    if (addr[1:0] == 2'b00 && idx >= `OPB_IDX_FIRST && idx <= `OPB_IDX_LAST) begin
      regSlot = {1'b1, `OPB_SLOT(idx)};
    end else begin
      regSlot = 4'h0;
    end
  endfunction

  function automatic logic [7:0] regReset(input int slot);
    if (slot == int'(`OPB_SLOT(`OPB_IDX_PWR))) begin
      regReset = `OPB_RST_PWR;
    end else begin
      regReset = `OPB_RST_DEFAULT;
    end
  endfunction

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------

  logic [7:0] regQ [`OPB_NUM_REGS];

  logic            awRdyQ;
  logic            wRdyQ;
  logic            awGotQ;
  logic            wGotQ;
  logic [7:0]      awAddrQ;
  logic [31:0]     wDataQ;
  logic [3:0]      wStrbQ;
  opb_wr_st_t      wrStQ;
  opb_rd_st_t      rdStQ;
  logic            syncQ;
  logic [12:0]     applAQ;
  logic [12:0]     applBQ;
  logic            alarmQ;
  logic [1:0]      brespQ;
  logic [31:0]     rdataQ;
  logic [1:0]      rrespQ;
  logic            arRdyQ;

  // ---------------------------------------------------------------
  // Write channel control
  // ---------------------------------------------------------------

  wire logic        awFire;
  wire logic        wFire;
  wire logic        awHave;
  wire logic        wHave;
  wire logic        wrFire;
  wire logic        bFire;
  wire logic [7:0]  wrAddr;
  wire logic [31:0] wrData;
  wire logic [3:0]  wrStrb;
  wire logic [3:0]  wrDec;
  wire logic        wrHit;
  wire logic [2:0]  wrSlot;
  wire logic        awGotD;
  wire logic        wGotD;
  opb_wr_st_t       wrStD;

  assign awFire = awvalid & awRdyQ;
  assign wFire  = wvalid & wRdyQ;
  assign awHave = awGotQ | awFire;
  assign wHave  = wGotQ | wFire;
  assign wrFire = (wrStQ == OPB_WR_IDLE) & awHave & wHave;
  assign bFire  = (wrStQ == OPB_WR_RESP) & bready;
  assign wrAddr = awGotQ ? awAddrQ : awaddr;
  assign wrData = wGotQ ? wDataQ : wdata;
  assign wrStrb = wGotQ ? wStrbQ : wstrb;
  assign wrDec  = regSlot(wrAddr);
  assign wrHit  = wrDec[3];
  assign wrSlot = wrDec[2:0];
  assign awGotD = awHave & ~wrFire;
  assign wGotD  = wHave & ~wrFire;

  always_comb begin
    wrStD = wrStQ;
    case (wrStQ)
      OPB_WR_IDLE: begin
        if (wrFire) begin
          wrStD = OPB_WR_RESP;
        end
      end
      OPB_WR_RESP: begin
        if (bready) begin
          wrStD = OPB_WR_IDLE;
        end
      end
      default: begin
        wrStD = OPB_WR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wrStQ  <= OPB_WR_IDLE;
      awGotQ <= 1'b0;
      wGotQ  <= 1'b0;
      awRdyQ <= 1'b0;
      wRdyQ  <= 1'b0;
      brespQ <= OPB_OKAY;
    end else begin
      wrStQ  <= wrStD;
      awGotQ <= awGotD;
      wGotQ  <= wGotD;
      awRdyQ <= (wrStD == OPB_WR_IDLE) & ~awGotD;
      wRdyQ  <= (wrStD == OPB_WR_IDLE) & ~wGotD;
      if (wrFire) begin
        brespQ <= wrHit ? OPB_OKAY : OPB_SLVERR;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (awFire) begin
      awAddrQ <= awaddr;
    end
    if (wFire) begin
      wDataQ <= wdata;
      wStrbQ <= wstrb;
    end
  end

  // ---------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------

  genvar gi;
  generate
    for (gi = 0; gi < `OPB_NUM_REGS; gi++) begin : gReg
      always_ff @(posedge clk) begin
        if (rst) begin
          regQ[gi] <= regReset(gi);
        end else if (wrFire && wrHit && wrSlot == 3'(gi) && wrStrb[0]) begin
          regQ[gi] <= wrData[7:0]; // [R1] [R2] [R3] [R4]
        end
      end
    end
  endgenerate

  wire logic [7:0] ofsALo;
  wire logic [7:0] ofsBLo;
  wire logic [7:0] ofsAHi;
  wire logic [7:0] ofsBHi;
  wire logic [7:0] pwrReg;
  wire logic [7:0] refReg;
  wire logic [12:0] stagedA;
  wire logic [12:0] stagedB;

  assign ofsALo  = regQ[`OPB_SLOT(`OPB_IDX_OFS_A_LO)];
  assign ofsBLo  = regQ[`OPB_SLOT(`OPB_IDX_OFS_B_LO)];
  assign ofsAHi  = regQ[`OPB_SLOT(`OPB_IDX_OFS_A_HI)];
  assign ofsBHi  = regQ[`OPB_SLOT(`OPB_IDX_OFS_B_HI)];
  assign pwrReg  = regQ[`OPB_SLOT(`OPB_IDX_PWR)];
  assign refReg  = regQ[`OPB_SLOT(`OPB_IDX_REF)];
  assign stagedA = {ofsAHi[`OPB_HI_MSB:`OPB_HI_LSB], ofsALo}; // [R1] [R3]
  assign stagedB = {ofsBHi[`OPB_HI_MSB:`OPB_HI_LSB], ofsBLo}; // [R2] [R4]

  // ---------------------------------------------------------------
  // Offset sync and applied offsets
  // ---------------------------------------------------------------

  wire logic syncD;

  assign syncD = wrFire & wrHit & (wrSlot == `OPB_SLOT(`OPB_IDX_OFS_A_LO)); // [R6]

  always_ff @(posedge clk) begin
    if (rst) begin
      syncQ  <= 1'b0;
      applAQ <= 13'h0000; // [R18]
      applBQ <= 13'h0000; // [R18]
    end else begin
      syncQ <= syncD;
      if (syncQ) begin
        applAQ <= stagedA; // [R6] [R7]
        applBQ <= stagedB; // [R6] [R7]
      end
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : gAdd
      wire logic [15:0] chIn;
      wire logic [12:0] chOfs;
      wire logic [15:0] chOut;
      assign chIn  = (gi == 0) ? sampleIn.a : sampleIn.b;
      assign chOfs = (gi == 0) ? applAQ : applBQ;
      opb_offset_add uAdd (
        .clk       (clk),
        .rst       (rst),
        .sampleIn  (chIn),
        .offset    (chOfs),
        .sampleOut (chOut)
      ); // [R5]
    end
  endgenerate

  assign sampleOut.a = gAdd[0].chOut;
  assign sampleOut.b = gAdd[1].chOut;

  // ---------------------------------------------------------------
  // Power, sleep and reference controls
  // ---------------------------------------------------------------

  assign ctrlOut.fourWireSerialSel = ofsBHi[`OPB_FOUR_WIRE_BIT]; // [R9]
  assign ctrlOut.clkPathSleepA     = ofsBHi[`OPB_CLK_SLP_A_BIT]; // [R10]
  assign ctrlOut.clkPathSleepB     = ofsBHi[`OPB_CLK_SLP_B_BIT]; // [R12]
  assign ctrlOut.tempSenseEn       = pwrReg[`OPB_TEMP_EN_BIT];   // [R13]
  assign ctrlOut.clkRecvSleep      = pwrReg[`OPB_RECV_SLP_BIT];  // [R14]
  assign ctrlOut.chanSleepB        = pwrReg[`OPB_SLEEP_B_BIT];   // [R15]
  assign ctrlOut.chanSleepA        = pwrReg[`OPB_SLEEP_A_BIT];   // [R16]
  assign ctrlOut.extRefSel         = refReg[`OPB_EXT_REF_BIT];   // [R17]

  // Alarm pin carries serial read data in four-wire mode
  wire logic alarmD;

  assign alarmD = ofsBHi[`OPB_FOUR_WIRE_BIT] ? serialReadData : alarmSource; // [R9]

  always_ff @(posedge clk) begin
    if (rst) begin
      alarmQ <= 1'b0;
    end else begin
      alarmQ <= alarmD;
    end
  end

  // ---------------------------------------------------------------
  // Read channel
  // ---------------------------------------------------------------

  wire logic       arFire;
  wire logic [3:0] rdDec;
  wire logic [7:0] rdByte;
  opb_rd_st_t      rdStD;

  assign arFire = arvalid & arRdyQ;
  assign rdDec  = regSlot(araddr);
  assign rdByte = rdDec[3] ? regQ[rdDec[2:0]] : 8'h00;

  always_comb begin
    rdStD = rdStQ;
    case (rdStQ)
      OPB_RD_IDLE: begin
        if (arFire) begin
          rdStD = OPB_RD_RESP;
        end
      end
      OPB_RD_RESP: begin
        if (rready) begin
          rdStD = OPB_RD_IDLE;
        end
      end
      default: begin
        rdStD = OPB_RD_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdStQ  <= OPB_RD_IDLE;
      arRdyQ <= 1'b0;
      rdataQ <= 32'h0000_0000;
      rrespQ <= OPB_OKAY;
    end else begin
      rdStQ  <= rdStD;
      arRdyQ <= (rdStD == OPB_RD_IDLE);
      if (arFire) begin
        rdataQ <= {24'h00_0000, rdByte};
        rrespQ <= rdDec[3] ? OPB_OKAY : OPB_SLVERR;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  assign awready          = awRdyQ;
  assign wready           = wRdyQ;
  assign bvalid           = (wrStQ == OPB_WR_RESP);
  assign bresp            = brespQ;
  assign arready          = arRdyQ;
  assign rvalid           = (rdStQ == OPB_RD_RESP);
  assign rdata            = rdataQ;
  assign rresp            = rrespQ;
  assign offsetSync       = syncQ;
  assign appliedOffsetA   = applAQ;
  assign appliedOffsetB   = applBQ;
  assign alarmReadDataPin = alarmQ;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  low_a_write_a: assert property (@(posedge clk) disable iff (rst) // [R1]
    wrFire && wrHit && wrSlot == `OPB_SLOT(`OPB_IDX_OFS_A_LO) && wrStrb[0]
    |=> ofsALo == $past(wrData[7:0]))
    else $error("channel A low offset byte not stored");

  high_b_write_a: assert property (@(posedge clk) disable iff (rst) // [R4]
    wrFire && wrHit && wrSlot == `OPB_SLOT(`OPB_IDX_OFS_B_HI) && wrStrb[0]
    |=> ofsBHi[`OPB_HI_MSB:`OPB_HI_LSB] == $past(wrData[7:3]))
    else $error("channel B high offset bits not stored");

  sync_on_low_a: assert property (@(posedge clk) disable iff (rst) // [R6]
    wrFire && wrHit && wrSlot == `OPB_SLOT(`OPB_IDX_OFS_A_LO)
    |=> offsetSync ##1 appliedOffsetA == $past(stagedA) && appliedOffsetB == $past(stagedB))
    else $error("offset sync did not load all four registers");

  offset_hold_a: assert property (@(posedge clk) disable iff (rst) // [R7]
    !syncQ |=> $stable(appliedOffsetA) && $stable(appliedOffsetB))
    else $error("applied offset changed without sync");

  reset_zero_a: assert property (@(posedge clk) disable iff (rst) // [R18]
    $past(rst) |-> appliedOffsetA == 13'h0000 && appliedOffsetB == 13'h0000
      && regQ[`OPB_SLOT(`OPB_IDX_PWR)] == `OPB_RST_PWR)
    else $error("reset values wrong after reset");

  alarm_share_a: assert property (@(posedge clk) disable iff (rst) // [R9]
    ctrlOut.fourWireSerialSel |=> alarmReadDataPin == $past(serialReadData))
    else $error("alarm pin not carrying serial read data");

  sleep_bits_a: assert property (@(posedge clk) disable iff (rst) // [R15] [R16]
    wrFire && wrHit && wrSlot == `OPB_SLOT(`OPB_IDX_PWR) && wrStrb[0]
    |=> ctrlOut.chanSleepB == $past(wrData[3]) && ctrlOut.chanSleepA == $past(wrData[2]))
    else $error("channel sleep controls did not follow write");

  temp_readback_a: assert property (@(posedge clk) disable iff (rst) // [R13]
    arFire && rdDec[3] && rdDec[2:0] == `OPB_SLOT(`OPB_IDX_PWR)
    |=> rvalid && rdata[`OPB_TEMP_EN_BIT] == $past(ctrlOut.tempSenseEn))
    else $error("temperature enable read back wrong");

  ref_select_a: assert property (@(posedge clk) disable iff (rst) // [R17]
    wrFire && wrHit && wrSlot == `OPB_SLOT(`OPB_IDX_REF) && wrStrb[0]
    |=> ctrlOut.extRefSel == $past(wrData[2]))
    else $error("reference select did not follow write");

endmodule

// *** tb/tb_offset_and_power_config_bank.sv ***
// Self-checking bench for the offset and power configuration bank
`timescale 1ns/1ps

module tb_offset_and_power_config_bank
  import opb_pkg::*;
();
  // ------------------------------------------------
  // Signals
  // ------------------------------------------------
  logic        clk;
  logic        rst;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  opb_pair_t   sampleIn;
  opb_pair_t   sampleOut;
  logic        offsetSync;
  logic [12:0] appliedOffsetA;
  logic [12:0] appliedOffsetB;
  opb_ctrl_t   ctrlOut;
  logic        serialReadData;
  logic        alarmSource;
  logic        alarmReadDataPin;
  int          bad_count;
  int          compares;
  int          cycles;
  int          syncCount;
  int          seed;
  int          regM [6];
  logic [31:0] expQ [$];

  opb_bank i_dut (
    .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .sampleIn, .sampleOut, .offsetSync, .appliedOffsetA,
    .appliedOffsetB, .ctrlOut, .serialReadData, .alarmSource, .alarmReadDataPin
  );

  always #2.5 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (!rst && offsetSync) begin
      syncCount <= syncCount + 1;
    end
    if (cycles == 8000) begin
      bad_count++;
      report_and_stop();
    end
  end

  // ------------------------------------------------
  // Checks and bus tasks
  // ------------------------------------------------
  task automatic report_and_stop();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected=%h seen=%h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    @(posedge clk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  task automatic put(input int idx, input logic [7:0] v);
    logic [1:0] r;
    wr(8'(4 * idx), {24'h0, v}, 4'hf, r);
    chk("bresp", 32'h0, 32'(r));
    regM[idx - 20] = int'(v);
  endtask

  task automatic check_regs();
    logic [31:0] d;
    logic [1:0]  r;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * (20 + i)), d, r);
      chk("rresp", 32'h0, 32'(r));
      chk("rdata", 32'(regM[i]), d);
    end
  endtask

  function automatic logic [31:0] exp_ctrl();
    return 32'({regM[3][2], regM[3][1], regM[3][0], regM[4][7],
                regM[4][6], regM[4][3], regM[4][2], regM[5][2]});
  endfunction

  function automatic logic [31:0] add_ofs(logic [15:0] s, int o);
    logic [12:0] o13;
    o13 = 13'(o);
    return 32'(16'(s + {{3{o13[12]}}, o13}));
  endfunction

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    int          n;
    int          aOfs;
    int          bOfs;
    opb_pair_t   s;
    logic [31:0] d;
    logic [1:0]  r;
    clk = 0; rst = 1; cycles = 0; syncCount = 0; bad_count = 0; compares = 0; seed = 87;
    awaddr = 0; awvalid = 0; wdata = 0; wstrb = 0; wvalid = 0; bready = 0;
    araddr = 0; arvalid = 0; rready = 0; sampleIn = '0;
    serialReadData = 0; alarmSource = 0;
    regM = '{0, 0, 0, 0, 'h83, 0};
    aOfs = 0;
    bOfs = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    check_regs();
    chk("ctrl", exp_ctrl(), 32'(ctrlOut));
    chk("ofsA", 32'h0, 32'(appliedOffsetA));
    chk("ofsB", 32'h0, 32'(appliedOffsetB));
    wr(8'h68, 32'h5a, 4'hf, r);
    chk("bresp", 32'h2, 32'(r));
    rd(8'h4c, d, r);
    chk("rresp", 32'h2, 32'(r));
    chk("rdata", 32'h0, d);
    for (int k = 0; k < 8; k++) begin
      n = syncCount;
      put(21, 8'($random(seed)));
      put(22, 8'($random(seed)) & 8'hf8);
      put(23, 8'($random(seed)));
      put(24, (8'($random(seed)) & 8'hcc) | 8'h03 |
          (((regM[3] & 3) != 0) ? 8'h4c : 8'h00));
      put(25, 8'($random(seed)) & 8'h04);
      repeat (4) @(posedge clk);
      chk("sync", 32'(n), 32'(syncCount));
      chk("ofsA", 32'(aOfs), 32'(appliedOffsetA));
      chk("ofsB", 32'(bOfs), 32'(appliedOffsetB));
      put(20, 8'($random(seed)));
      repeat (4) @(posedge clk);
      aOfs = ((regM[2] >> 3) << 8) | regM[0];
      bOfs = ((regM[3] >> 3) << 8) | regM[1];
      chk("sync", 32'(n + 1), 32'(syncCount));
      chk("ofsA", 32'(aOfs), 32'(appliedOffsetA));
      chk("ofsB", 32'(bOfs), 32'(appliedOffsetB));
      s = opb_pair_t'($random(seed));
      sampleIn <= s;
      expQ.push_back(add_ofs(s.a, aOfs));
      expQ.push_back(add_ofs(s.b, bOfs));
      repeat (3) @(posedge clk);
      chk("sampleA", expQ.pop_front(), 32'(sampleOut.a));
      chk("sampleB", expQ.pop_front(), 32'(sampleOut.b));
      chk("ctrl", exp_ctrl(), 32'(ctrlOut));
      check_regs();
    end
    n = syncCount;
    put(21, 8'h3c);
    wr(8'h50, 32'h00a5, 4'h0, r);
    chk("bresp", 32'h0, 32'(r));
    repeat (4) @(posedge clk);
    bOfs = ((regM[3] >> 3) << 8) | regM[1];
    chk("sync", 32'(n + 1), 32'(syncCount));
    chk("ofsA", 32'(aOfs), 32'(appliedOffsetA));
    chk("ofsB", 32'(bOfs), 32'(appliedOffsetB));
    check_regs();
    for (int k = 0; k < 4; k++) begin
      put(23, k[1] ? 8'h04 : 8'h00);
      serialReadData <= k[0];
      alarmSource    <= !k[0];
      repeat (3) @(posedge clk);
      chk("alarm", 32'(k[1] ? k[0] : !k[0]), 32'(alarmReadDataPin));
    end
    report_and_stop();
  end
endmodule
